/* opmc_ctrl.sv */
// host controller for the optical proximity sensor pins
`timescale 1ns/1ps
`include "opmc_cfg.svh"
// Behaviour
// - mode and strobe pins driven valid always
// - pins captured at falling edge, then static
// - shutdown/clock stays low while mode active
// - each measurement starts with strobe rise
// - strobe held low through power-up wait
// - missing pulse retried by toggling strobe
// - dropping strobe aborts the cycle early
// - pulse low at strobe fall means near
// - strobe repetition sets measurement rate
// - mode zero strobe limited to 1 ms
module opmc_ctrl #(
    parameter int AW = 8,
    parameter int unsigned LATENCY_CYC = `OPMC_LATENCY_CYC,
    parameter int unsigned STX_MAX_CYC = `OPMC_MODE0_STX_MAX_CYC,
    parameter int unsigned PERIOD_RST = `OPMC_RATE_CYC,
    parameter int unsigned RETRIES = `OPMC_RETRIES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] busAddr,
    input wire logic [31:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [31:0] busRdata,
    output logic shutdownClockPin,
    output logic modeSelectPin,
    output logic strobeTransmitPin,
    input wire logic pulseWidthOutput
);
    import opmc_pkg::*;

    localparam opmc_cnt_t SETUP = opmc_cnt_t'(`OPMC_SETUP_CYC);
    localparam opmc_cnt_t LATENCY = opmc_cnt_t'(LATENCY_CYC);
    localparam opmc_cnt_t STXMAX = opmc_cnt_t'(STX_MAX_CYC);
    localparam logic [1:0] RETRY_MAX = 2'(RETRIES);

    opmc_ctrl_s st_ff;
    opmc_ctrl_s nxt_st;
    logic pulseSync;
    opmc_cnt_t meterWidth;
    logic meterLow;
    logic meterEnded;

    // ==========================================================
    // helpers

    // saturating decrement of a timer
    function automatic opmc_cnt_t dec(input opmc_cnt_t v);
        dec = (v == '0) ? '0 : v - opmc_cnt_t'(1);
    endfunction

    // strobe window for the active mode, never zero
    function automatic opmc_cnt_t effWidth(input logic [2:0] m,
                                           input opmc_cnt_t w);
        effWidth = (w == '0) ? opmc_cnt_t'(1) : w;
        if (m == PROX_HIGH_CURRENT_MODE && effWidth > STXMAX) begin
            effWidth = STXMAX;
        end
    endfunction

    // raise strobe and arm the meter for a new cycle
    function automatic opmc_ctrl_s startStrobe(input opmc_ctrl_s s);
        startStrobe = s;
        startStrobe.state = ST_STROBE;
        startStrobe.stxPin = 1'b1;
        startStrobe.tmr = effWidth(s.mode, s.widthReg);
        startStrobe.perTmr = s.periodReg;
        startStrobe.meterClr = 1'b1;
    endfunction

    // status word
    function automatic logic [31:0] statusWord(input opmc_ctrl_s s);
        statusWord = '0;
        statusWord[`OPMC_ST_READY] = (s.state == ST_IDLE);
        statusWord[`OPMC_ST_BUSY] = (s.state == ST_STROBE);
        statusWord[`OPMC_ST_VALID] = s.resValid;
        statusWord[`OPMC_ST_NEAR] = s.near;
        statusWord[`OPMC_ST_NOPULSE] = s.noPulse;
        statusWord[`OPMC_ST_BADMODE] = s.badMode;
        statusWord[`OPMC_ST_SHUT] = s.scPin;
        statusWord[`OPMC_ST_MODE_HI:`OPMC_ST_MODE_LO] = s.mode;
    endfunction

    // ==========================================================
    // pulse input path

    // pin from the sensor, no clock relation
    opmc_sync #(
        .RST_VAL(1'b1)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(pulseWidthOutput),
        .pinOut(pulseSync)
    );

    // low-time measurement while strobe is high
    opmc_meter u_meter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(st_ff.meterClr),
        .armed(st_ff.stxPin),
        .pulseIn(pulseSync),
        .width(meterWidth),
        .lowSeen(meterLow),
        .ended(meterEnded)
    );

    // ==========================================================
    // next state

    // bus access, sequencer, then start requests
    always_comb begin
        nxt_st = st_ff;
        nxt_st.meterClr = 1'b0;
        nxt_st.rdata = '0;
        nxt_st.perTmr = dec(st_ff.perTmr);

        // register writes and flag clears, before hardware sets
        if (busWr) begin
            unique case (busAddr)
                AW'(`OPMC_OFS_CTRL): begin
                    nxt_st.enable = busWdata[`OPMC_CTRL_EN];
                    nxt_st.cont = busWdata[`OPMC_CTRL_CONT];
                    if (busWdata[`OPMC_CTRL_MODE_HI:`OPMC_CTRL_MODE_LO]
                        == RESERVED_MODE) begin
                        nxt_st.badMode = 1'b1;
                    end else begin
                        nxt_st.modeReq =
                            busWdata[`OPMC_CTRL_MODE_HI:`OPMC_CTRL_MODE_LO];
                    end
                end
                AW'(`OPMC_OFS_PERIOD): begin
                    nxt_st.periodReg = busWdata[`OPMC_CNT_W-1:0];
                end
                AW'(`OPMC_OFS_WIDTH): begin
                    nxt_st.widthReg = busWdata[`OPMC_CNT_W-1:0];
                end
                AW'(`OPMC_OFS_STATUS): begin
                    if (busWdata[`OPMC_ST_NOPULSE]) begin
                        nxt_st.noPulse = 1'b0;
                    end
                    if (busWdata[`OPMC_ST_BADMODE]) begin
                        nxt_st.badMode = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // read data for the next cycle, unmapped reads give zero
        if (busRd) begin
            unique case (busAddr)
                AW'(`OPMC_OFS_CTRL): begin
                    nxt_st.rdata[`OPMC_CTRL_EN] = st_ff.enable;
                    nxt_st.rdata[`OPMC_CTRL_CONT] = st_ff.cont;
                    nxt_st.rdata[`OPMC_CTRL_MODE_HI:`OPMC_CTRL_MODE_LO] =
                        st_ff.modeReq;
                end
                AW'(`OPMC_OFS_PERIOD): begin
                    nxt_st.rdata[`OPMC_CNT_W-1:0] = st_ff.periodReg;
                end
                AW'(`OPMC_OFS_WIDTH): begin
                    nxt_st.rdata[`OPMC_CNT_W-1:0] = st_ff.widthReg;
                end
                AW'(`OPMC_OFS_STATUS): begin
                    nxt_st.rdata = statusWord(st_ff);
                end
                AW'(`OPMC_OFS_RESULT): begin
                    nxt_st.rdata[`OPMC_CNT_W-1:0] = st_ff.result;
                    nxt_st.resValid = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // leave the active mode on disable or a new mode request
        if (st_ff.state != ST_SHUT &&
            (!st_ff.enable || st_ff.modeReq != st_ff.mode)) begin
            nxt_st.state = ST_SHUT;
            nxt_st.scPin = 1'b1;
            nxt_st.mdPin = 1'b0;
            nxt_st.stxPin = 1'b0;
            nxt_st.retryPend = 1'b0;
            nxt_st.tmr = SETUP;
        end else begin
            unique case (st_ff.state)
                // shutdown, shutdown/clock high, mode and strobe parked low, pulse input ignored
                ST_SHUT: begin
                    nxt_st.scPin = 1'b1;
                    nxt_st.mdPin = 1'b0;
                    nxt_st.stxPin = 1'b0;
                    nxt_st.tmr = dec(st_ff.tmr);
                    if (st_ff.enable && st_ff.tmr == '0) begin
                        nxt_st.state = ST_SETUP;
                        nxt_st.mode = st_ff.modeReq;
                        nxt_st.stxPin = st_ff.modeReq[2];
                        nxt_st.mdPin = st_ff.modeReq[1];
                        nxt_st.tmr = SETUP;
                    end
                end
                // latched levels settle before the falling edge
                ST_SETUP: begin
                    nxt_st.tmr = dec(st_ff.tmr);
                    if (st_ff.tmr == '0) begin
                        nxt_st.state = ST_LATCH;
                        nxt_st.scPin = 1'b0;
                        nxt_st.tmr = SETUP;
                    end
                end
                // hold after the edge, then static mode bit
                ST_LATCH: begin
                    nxt_st.tmr = dec(st_ff.tmr);
                    if (st_ff.tmr == '0) begin
                        nxt_st.state = ST_WARM;
                        nxt_st.mdPin = st_ff.mode[0];
                        nxt_st.stxPin = 1'b0;
                        nxt_st.tmr = LATENCY;
                    end
                end
                // power-up wait with strobe low
                ST_WARM: begin
                    nxt_st.tmr = dec(st_ff.tmr);
                    if (st_ff.tmr == '0) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.retries = '0;
                    end
                end
                // mode active, shutdown/clock kept low
                ST_IDLE: begin
                    nxt_st.scPin = 1'b0;
                    if (st_ff.startPend ||
                        (st_ff.cont && st_ff.perTmr == '0)) begin
                        nxt_st = startStrobe(nxt_st);
                        nxt_st.startPend = 1'b0;
                    end
                end
                // measurement running
                ST_STROBE: begin
                    nxt_st.tmr = dec(st_ff.tmr);
                    if (meterEnded && !st_ff.meterClr) begin // old end flag
                        // pulse rose, LED already off in the sensor
                        nxt_st.stxPin = 1'b0;
                        nxt_st.result = meterWidth;
                        nxt_st.resValid = 1'b1;
                        nxt_st.near = 1'b0;
                        nxt_st.retries = '0;
                        nxt_st.state = ST_GAP;
                        nxt_st.tmr = SETUP;
                    end else if (st_ff.tmr == '0) begin
                        nxt_st.stxPin = 1'b0;
                        nxt_st.near = !pulseSync;
                        nxt_st.state = ST_GAP;
                        nxt_st.tmr = SETUP;
                        if (meterLow) begin
                            nxt_st.result = meterWidth;
                            nxt_st.resValid = 1'b1;
                            nxt_st.retries = '0;
                        end else begin
                            nxt_st.noPulse = 1'b1;
                            if (st_ff.retries != RETRY_MAX) begin
                                nxt_st.retryPend = 1'b1;
                                nxt_st.retries = st_ff.retries + 2'h1;
                            end
                        end
                    end
                end
                // strobe low gap, retry re-raises strobe
                ST_GAP: begin
                    nxt_st.tmr = dec(st_ff.tmr);
                    if (st_ff.tmr == '0) begin
                        if (st_ff.retryPend) begin
                            nxt_st = startStrobe(nxt_st);
                            nxt_st.retryPend = 1'b0;
                        end else begin
                            nxt_st.state = ST_IDLE;
                        end
                    end
                end
            endcase
        end

        // software start request, after the sequencer's clear
        if (busWr && busAddr == AW'(`OPMC_OFS_CTRL) &&
            busWdata[`OPMC_CTRL_START]) begin
            nxt_st.startPend = 1'b1;
        end
    end

    // ==========================================================
    // state register

    // reset parks the sensor in shutdown
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.state <= ST_SHUT;
            st_ff.scPin <= 1'b1;
            st_ff.tmr <= SETUP;
            st_ff.periodReg <= opmc_cnt_t'(PERIOD_RST);
            st_ff.widthReg <= STXMAX;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busRdata = st_ff.rdata;
    assign shutdownClockPin = st_ff.scPin;
    assign modeSelectPin = st_ff.mdPin;
    assign strobeTransmitPin = st_ff.stxPin;
endmodule

/* opmc_cfg.svh */
// offsets, field positions, reset values and timing counts
`ifndef OPMC_CFG_SVH
`define OPMC_CFG_SVH

// ==========================================================
// clock and timing
`define OPMC_CLK_MHZ 25
`define OPMC_CNT_W 24
`define OPMC_LATENCY_US 500
`define OPMC_LATENCY_CYC (`OPMC_LATENCY_US * `OPMC_CLK_MHZ)
`define OPMC_SETUP_US 1
`define OPMC_SETUP_CYC (`OPMC_SETUP_US * `OPMC_CLK_MHZ)
`define OPMC_MODE0_STX_MAX_MS 1
`define OPMC_MODE0_STX_MAX_CYC (`OPMC_MODE0_STX_MAX_MS * 1000 * `OPMC_CLK_MHZ)
`define OPMC_RATE_HZ 250
`define OPMC_RATE_CYC ((`OPMC_CLK_MHZ * 1000000) / `OPMC_RATE_HZ)
`define OPMC_RETRIES 3

// ==========================================================
// register offsets
`define OPMC_OFS_CTRL 8'h00
`define OPMC_OFS_PERIOD 8'h04
`define OPMC_OFS_WIDTH 8'h08
`define OPMC_OFS_STATUS 8'h0c
`define OPMC_OFS_RESULT 8'h10

// ==========================================================
// control fields
`define OPMC_CTRL_EN 0
`define OPMC_CTRL_MODE_LO 1
`define OPMC_CTRL_MODE_HI 3
`define OPMC_CTRL_START 4
`define OPMC_CTRL_CONT 5

// ==========================================================
// status fields
`define OPMC_ST_READY 0
`define OPMC_ST_BUSY 1
`define OPMC_ST_VALID 2
`define OPMC_ST_NEAR 3
`define OPMC_ST_NOPULSE 4
`define OPMC_ST_BADMODE 5
`define OPMC_ST_SHUT 6
`define OPMC_ST_MODE_LO 8
`define OPMC_ST_MODE_HI 10

`endif

/* opmc_pkg.sv */
// types shared by the proximity mode controller
`include "opmc_cfg.svh"
package opmc_pkg;
    typedef enum logic [2:0] {
        PROX_HIGH_CURRENT_MODE = 3'h0,
        OFFSET_CALIBRATION_MODE = 3'h1,
        PROX_LOW_CURRENT_MODE = 3'h2,
        PROX_LOW_CURRENT_HIGH_REFLECT_MODE = 3'h3,
        VIS_IR_AMBIENT_LOW_MODE = 3'h4,
        VISIBLE_AMBIENT_MODE = 3'h5,
        VIS_IR_AMBIENT_HIGH_MODE = 3'h6,
        RESERVED_MODE = 3'h7
    } opmc_mode_e;

    typedef enum logic [2:0] {
        ST_SHUT, ST_SETUP, ST_LATCH, ST_WARM, ST_IDLE, ST_STROBE, ST_GAP
    } opmc_state_e;

    typedef logic [`OPMC_CNT_W-1:0] opmc_cnt_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } opmc_sync_s;

    typedef struct packed {
        opmc_cnt_t cnt;
        logic lowSeen;
        logic ended;
    } opmc_meter_s;

    typedef struct packed {
        opmc_state_e state;
        logic scPin;
        logic mdPin;
        logic stxPin;
        logic enable;
        logic cont;
        logic startPend;
        logic retryPend;
        logic meterClr;
        logic [2:0] modeReq;
        logic [2:0] mode;
        opmc_cnt_t tmr;
        opmc_cnt_t perTmr;
        opmc_cnt_t periodReg;
        opmc_cnt_t widthReg;
        opmc_cnt_t result;
        logic resValid;
        logic near;
        logic noPulse;
        logic badMode;
        logic [1:0] retries;
        logic [31:0] rdata;
    } opmc_ctrl_s;
endpackage

/* opmc_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module opmc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic pinOut
);
    import opmc_pkg::*;

    opmc_sync_s st_ff;
    opmc_sync_s nxt_st;

    // shift chain, output follows once stages two and three agree
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pinIn;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.out = st_ff.s3;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, out: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pinOut = st_ff.out;
endmodule

/* opmc_meter.sv */
// low-time meter for the device pulse output
`timescale 1ns/1ps
`include "opmc_cfg.svh"
module opmc_meter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic armed,
    input wire logic pulseIn,
    output opmc_pkg::opmc_cnt_t width,
    output logic lowSeen,
    output logic ended
);
    import opmc_pkg::*;

    opmc_meter_s st_ff;
    opmc_meter_s nxt_st;

    // count low cycles while armed, stop at the rising edge
    always_comb begin
        nxt_st = st_ff;
        if (clear) begin
            nxt_st = '0;
        end else if (armed && !st_ff.ended) begin
            if (!pulseIn) begin
                nxt_st.lowSeen = 1'b1;
                if (st_ff.cnt != '1) begin
                    nxt_st.cnt = st_ff.cnt + opmc_cnt_t'(1);
                end
            end else if (st_ff.lowSeen) begin
                nxt_st.ended = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign width = st_ff.cnt;
    assign lowSeen = st_ff.lowSeen;
    assign ended = st_ff.ended;
endmodule

/* opmc_sensor_model.sv */
// behavioural sensor that answers the controller pins
`timescale 1ns/1ps
module opmc_sensor_model #(
    parameter int LAT = 50,
    parameter int DLY = 4
) (
    input wire logic core_clk,
    input wire logic sc,
    input wire logic md,
    input wire logic strobe_transmit_pin,
    input wire logic [15:0] lowLen,
    output wire logic pulse_width_output,
    output wire logic led
);
    logic scD = 1'b1;
    logic stxD = 1'b0;
    logic [1:0] lat = 2'h0;
    logic busy = 1'b0;
    logic low = 1'b0;
    logic early = 1'b0;
    int warm = 0;
    int cnt = 0;
    int rises = 0;
    int ledCyc = 0;
    wire logic [2:0] mode = {lat, md};
    // ==========================================================
    // outputs: pulse floats in shutdown, led only in led modes
    assign pulse_width_output = sc ? 1'bz : !low;
    assign led = low && (mode == 3'h0 || mode[2:1] == 2'b01);
    // mode latch, power-up wait and measurement cycle
    always @(posedge core_clk) begin
        scD <= sc;
        stxD <= strobe_transmit_pin;
        if (led) ledCyc <= ledCyc + 1;
        if (sc) begin
            busy <= 1'b0;
            low <= 1'b0;
            warm <= 0;
        end else if (scD) begin
            lat <= {strobe_transmit_pin, md};
        end else begin
            if (warm < LAT) warm <= warm + 1;
            if (strobe_transmit_pin && !stxD) begin
                rises <= rises + 1;
                if (warm < LAT) early <= 1'b1;
                else busy <= 1'b1;
                cnt <= 0;
            end else if (busy && !strobe_transmit_pin) begin
                busy <= 1'b0;
                low <= 1'b0;
            end else if (busy) begin
                cnt <= cnt + 1;
                low <= lowLen != 0 && cnt >= DLY && cnt < DLY + lowLen;
                if (cnt >= DLY + lowLen) busy <= 1'b0;
            end
        end
    end
endmodule

/* opmc_ctrl_monitor.sv */
// pin assertions for the proximity mode controller
`timescale 1ns/1ps
module opmc_ctrl_monitor #(
    parameter int unsigned LATENCY_CYC = 50,
    parameter int unsigned STX_MAX_CYC = 200
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic shutdownClockPin,
    input wire logic modeSelectPin,
    input wire logic strobeTransmitPin,
    input wire logic pulseWidthOutput
);
    logic [23:0] scLow;
    logic [23:0] stxHigh;
    logic [1:0] latBits;
    // ==========================================================
    // cycles since the latch edge, strobe run length, latched bits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scLow <= 24'h0;
            stxHigh <= 24'h0;
            latBits <= 2'h0;
        end else begin
            scLow <= shutdownClockPin ? 24'h0 : scLow + {23'h0, ~&scLow};
            stxHigh <= (strobeTransmitPin && !shutdownClockPin) ?
                stxHigh + 24'h1 : 24'h0;
            if (!shutdownClockPin && scLow == 24'h0) begin
                latBits <= {strobeTransmitPin, modeSelectPin};
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // properties
    property p_latchHold;
        $fell(shutdownClockPin) |->
            ($stable(modeSelectPin) && $stable(strobeTransmitPin)) [*8];
    endproperty
    a_latchHold: assert property (p_latchHold)
        else $error("mode pins moved right after the latch edge");
    property p_warmLow;
        $rose(strobeTransmitPin) && !shutdownClockPin |->
            scLow >= LATENCY_CYC + 26;
    endproperty
    a_warmLow: assert property (p_warmLow)
        else $error("strobe raised inside the power-up wait");
    property p_shutPins;
        $rose(shutdownClockPin) |->
            (!modeSelectPin && !strobeTransmitPin) [*8];
    endproperty
    a_shutPins: assert property (p_shutPins)
        else $error("mode or strobe high at shutdown");
    property p_gapLow;
        $fell(strobeTransmitPin) && !shutdownClockPin |->
            !strobeTransmitPin [*8];
    endproperty
    a_gapLow: assert property (p_gapLow)
        else $error("strobe toggled back too soon");
    property p_pulseEnd;
        $rose(pulseWidthOutput) && strobeTransmitPin && !shutdownClockPin
            |-> ##[1:8] !strobeTransmitPin;
    endproperty
    a_pulseEnd: assert property (p_pulseEnd)
        else $error("strobe kept high after the pulse ended");
    property p_mode0Max;
        !shutdownClockPin && scLow > 24'd30 && latBits == 2'b00 &&
            !modeSelectPin |-> stxHigh <= STX_MAX_CYC + 2;
    endproperty
    a_mode0Max: assert property (p_mode0Max)
        else $error("strobe too long in high current mode");
    property p_noReserved;
        $rose(strobeTransmitPin) && !shutdownClockPin |->
            !(latBits == 2'b11 && modeSelectPin);
    endproperty
    a_noReserved: assert property (p_noReserved)
        else $error("measurement started in the reserved mode");
    property p_staticHold;
        !shutdownClockPin && scLow > 24'd30 |-> $stable(modeSelectPin);
    endproperty
    a_staticHold: assert property (p_staticHold)
        else $error("static mode pin moved while active");
    c_measure: cover property ($rose(strobeTransmitPin) && !shutdownClockPin);
    c_program: cover property ($fell(shutdownClockPin));
    c_abort: cover property ($fell(strobeTransmitPin) && !pulseWidthOutput);
endmodule
bind opmc_ctrl opmc_ctrl_monitor #(
    .LATENCY_CYC(LATENCY_CYC),
    .STX_MAX_CYC(STX_MAX_CYC)
) mon (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .shutdownClockPin(shutdownClockPin),
    .modeSelectPin(modeSelectPin),
    .strobeTransmitPin(strobeTransmitPin),
    .pulseWidthOutput(pulseWidthOutput)
);

/* tb_optical_proximity_mode_control.sv */
// self-checking bench for the proximity mode controller
`timescale 1ns/1ps
`include "opmc_cfg.svh"
module tb_optical_proximity_mode_control;
    typedef struct {
        logic [31:0] exp;
        logic [31:0] msk;
        logic [31:0] tol;
        string what;
    } opmc_note_s;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] busAddr = 8'h00;
    logic [31:0] busWdata = 32'h0;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic rdLast = 1'b0;
    logic [15:0] lowLen = 16'h0;
    logic [31:0] busRdata;
    logic [31:0] seen;
    logic ok;
    wire scPin;
    wire mdPin;
    wire stxPin;
    tri1 prxNet;
    opmc_note_s notes[$];
    opmc_note_s nt;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int n, k, r0;
    opmc_ctrl #(.LATENCY_CYC(50), .STX_MAX_CYC(200), .PERIOD_RST(300)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .busAddr(busAddr),
        .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
        .busRdata(busRdata), .shutdownClockPin(scPin),
        .modeSelectPin(mdPin), .strobeTransmitPin(stxPin),
        .pulseWidthOutput(prxNet));
    opmc_sensor_model #(.LAT(50), .DLY(4)) sensor (
        .core_clk(core_clk), .sc(scPin), .md(mdPin), .strobe_transmit_pin(stxPin),
        .lowLen(lowLen), .pulse_width_output(prxNet), .led());
    always #20 core_clk = ~core_clk;
    // ==========================================================
    // compare, verdict and bus tasks
    task automatic check(input string what, input logic [31:0] s,
                         input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        busAddr <= a;
        busWdata <= d;
        busWr <= 1'b1;
        @(posedge core_clk);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [31:0] t,
                      input string w);
        notes.push_back('{e, m, t, w});
        @(posedge core_clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge core_clk);
        busRd <= 1'b0;
    endtask
    task automatic waitPin(input logic onStx, input logic v, output int c);
        c = 0;
        while ((onStx ? stxPin : scPin) !== v && c < 1000) begin
            @(posedge core_clk);
            c++;
        end
        if (c >= 1000) check("pin wait", 32'(!v), 32'(v));
    endtask
    // program a new mode and run one strobe, c is the high time
    task automatic measure(output int c);
        waitPin(1'b0, 1'b1, c);
        waitPin(1'b0, 1'b0, c);
        repeat (30) @(posedge core_clk);
        waitPin(1'b1, 1'b1, c);
        waitPin(1'b1, 1'b0, c);
    endtask
    // read checker and watchdog
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        rdLast <= busRd;
        if (rdLast) begin
            nt = notes.pop_front();
            seen = busRdata & nt.msk;
            ok = (seen + nt.tol - nt.exp) <= 2 * nt.tol;
            check(nt.what, ok ? nt.exp : seen, nt.exp);
        end
        if (cyc == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hdb6ebabf));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`OPMC_OFS_STATUS, 32'h40, 32'h77f, 0, "reset status");
        rd(`OPMC_OFS_PERIOD, 32'd300, 32'hffffffff, 0, "reset period");
        rd(8'h14, 32'h0, 32'hffffffff, 0, "unmapped read");
        wr(`OPMC_OFS_WIDTH, 32'd150);
        for (int m = 0; m < 7; m++) begin
            lowLen <= 16'($urandom_range(60, 10));
            r0 = sensor.ledCyc;
            wr(`OPMC_OFS_CTRL, 32'h11 | (m << 1));
            measure(n);
            check("latched mode", 32'(sensor.mode), 32'(m));
            check("early strobe", 32'(sensor.early), 32'h0);
            check("led", 32'(sensor.ledCyc > r0), 32'(m inside {0, 2, 3}));
            repeat (40) @(posedge core_clk);
            rd(`OPMC_OFS_STATUS, 32'h5 | (m << 8), 32'h70f, 0, "status");
            rd(`OPMC_OFS_RESULT, 32'(lowLen), 32'hffffffff, 2, "result");
        end
        // high current mode, pulse outlasts the clamped window
        lowLen <= 16'd400;
        wr(`OPMC_OFS_WIDTH, 32'd1000);
        wr(`OPMC_OFS_CTRL, 32'h11);
        measure(n);
        check("clamped window", 32'(n >= 199 && n <= 203), 32'h1);
        repeat (40) @(posedge core_clk);
        rd(`OPMC_OFS_STATUS, 32'h8, 32'h8, 0, "near flag");
        // silent sensor, strobe retried
        lowLen <= 16'd0;
        wr(`OPMC_OFS_WIDTH, 32'd20);
        r0 = sensor.rises;
        wr(`OPMC_OFS_CTRL, 32'h11);
        repeat (400) @(posedge core_clk);
        check("attempts", 32'(sensor.rises - r0), 32'd4);
        rd(`OPMC_OFS_STATUS, 32'h10, 32'h10, 0, "no pulse flag");
        wr(`OPMC_OFS_CTRL, 32'h0f);
        rd(`OPMC_OFS_STATUS, 32'h20, 32'h720, 0, "reserved mode");
        rd(`OPMC_OFS_CTRL, 32'h1, 32'h3f, 0, "ctrl");
        wr(`OPMC_OFS_STATUS, 32'h30);
        // continuous strobes at a set period
        lowLen <= 16'd10;
        wr(`OPMC_OFS_PERIOD, 32'd100);
        wr(`OPMC_OFS_CTRL, 32'h21);
        waitPin(1'b1, 1'b1, n);
        waitPin(1'b1, 1'b0, n);
        waitPin(1'b1, 1'b1, k);
        check("period", 32'((n + k) >= 100 && (n + k) <= 102), 32'h1);
        wr(`OPMC_OFS_CTRL, 32'h0);
        repeat (4) @(posedge core_clk);
        rd(`OPMC_OFS_STATUS, 32'h40, 32'h40, 0, "shut flag");
        repeat (4) @(posedge core_clk);
        report_and_stop();
    end
endmodule
